/* rtl/nand_host.sv */
// Purpose: Host sequencer driving a byte-wide NAND flash through its pins
// Assumes: Pin inputs synchronous to CLOCK; one request per handshake
// Notes:   Read bytes pass through a two-entry buffer toward the user
`timescale 1ns/1ps
`default_nettype none
module nand_host #(
  parameter int unsigned PROG_TMO  = nand_host_pkg::PROG_TMO_CYC,
  parameter int unsigned ERASE_TMO = nand_host_pkg::ERASE_TMO_CYC
) (
  // Clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RST,
  // Request side
  input  wire logic       REQ_VALID,
  output logic            REQ_READY,
  input  wire logic [2:0] REQ_OP,
  input  wire logic [1:0] REQ_BUSY_KIND,
  input  wire logic       REQ_HOLD_SELECT,
  input  wire logic       REQ_LOCK_N,
  input  wire logic [7:0] REQ_DATA,
  // Read data side
  output logic            RD_VALID,
  input  wire logic       RD_READY,
  output logic [7:0]      RD_DATA,
  // Status
  output logic            BUSY_DONE,
  output logic            TIMEOUT_FAULT,
  // Flash pins
  output logic            CMD_LATCH,
  output logic            ADDR_LATCH,
  output logic            CHIP_SEL_N,
  output logic            WRITE_STROBE_N,
  output logic            OUTPUT_STROBE_N,
  output logic            WRITE_LOCK_N,
  output logic [7:0]      IO_OUT,
  output logic            IO_OE,
  input  wire logic [7:0] IO_IN,
  input  wire logic       READY_BUSY_N
);
  typedef enum logic [2:0] {
    S_IDLE, S_WLOW, S_WHIGH, S_RLOW, S_RHIGH, S_BUSY
  } state_t;

  state_t               state_ff, nxt_state;
  logic [31:0]          cnt_ff;
  nand_host_pkg::busy_t bkind_ff;
  logic [7:0]           rbuf_ff [2];
  logic                 wp_ff, rp_ff;
  logic [1:0]           fill_ff;
  logic                 seen_busy_ff;

  // Request decode
  wire nand_host_pkg::op_t req_op = nand_host_pkg::op_t'(REQ_OP);
  wire logic  cnt_zero   = (cnt_ff == 32'h0);
  wire logic  take       = REQ_VALID && REQ_READY;
  wire logic  rd_pop     = RD_VALID && RD_READY;
  wire logic  rd_push    = (state_ff == S_RLOW) && cnt_zero;
  wire logic [1:0] fill_nxt = fill_ff + {1'b0, rd_push} - {1'b0, rd_pop};
  // Ready is withheld while a read could overflow the buffer; with no
  // request offered yet the next one may be a read, so it waits too
  wire logic  rd_blocked = (fill_nxt == 2'h2) &&
                           (!REQ_VALID || req_op == nand_host_pkg::OP_RDATA);
  wire logic  can_take   = (nxt_state == S_IDLE) && !rd_blocked;
  // lock high from the start of program or erase wait
  wire logic  lock_nxt   = REQ_LOCK_N ||
                           ((req_op == nand_host_pkg::OP_WAIT) &&
                            (REQ_BUSY_KIND != nand_host_pkg::BUSY_READ));
  // Buffer head after this cycle's push and pop
  wire logic [7:0] head_nxt =
    ((fill_ff == 2'h0) || (rd_pop && fill_ff == 2'h1)) ? IO_IN :
    rd_pop ? rbuf_ff[!rp_ff] : rbuf_ff[rp_ff];
  wire logic  ready_seen = READY_BUSY_N && seen_busy_ff;
  wire logic [31:0] tmo_lim = (bkind_ff == nand_host_pkg::BUSY_ERASE)
                              ? ERASE_TMO[31:0] : PROG_TMO[31:0];
  wire logic  tmo_hit    = (bkind_ff != nand_host_pkg::BUSY_READ) &&
                           (cnt_ff >= tmo_lim);

  // Next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_IDLE: begin
        if (take) begin
          if (req_op == nand_host_pkg::OP_RDATA)
            nxt_state = S_RLOW;
          else if (req_op == nand_host_pkg::OP_WAIT)
            nxt_state = S_BUSY;
          else
            nxt_state = S_WLOW;
        end
      end
      S_WLOW:  if (cnt_zero) nxt_state = S_WHIGH;
      S_WHIGH: if (cnt_zero) nxt_state = S_IDLE;
      S_RLOW:  if (cnt_zero) nxt_state = S_RHIGH;
      S_RHIGH: if (cnt_zero) nxt_state = S_IDLE;
      S_BUSY:  if (ready_seen || tmo_hit) nxt_state = S_IDLE;
    endcase
  end

  // State, counter and request capture
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_ff <= S_IDLE;
      cnt_ff   <= 32'h0;
      bkind_ff <= nand_host_pkg::BUSY_READ;
    end else begin
      state_ff <= nxt_state;
      if (take) begin
        bkind_ff <= nand_host_pkg::busy_t'(REQ_BUSY_KIND);
        cnt_ff   <= (req_op == nand_host_pkg::OP_RDATA)
                    ? 32'(nand_host_pkg::OUT_STB_LOW_CYC - 1)
                    : (req_op == nand_host_pkg::OP_WAIT) ? 32'h0
                    : 32'(nand_host_pkg::WE_LOW_CYC - 1);
      end else if (state_ff == S_BUSY) begin
        cnt_ff <= cnt_ff + 32'h1;
      end else if (!cnt_zero) begin
        cnt_ff <= cnt_ff - 32'h1;
      end else if (state_ff == S_WLOW) begin
        // Turnaround before a read strobe after a write cycle
        cnt_ff <= 32'(nand_host_pkg::WHR_CYC - 1);
      end else if (state_ff == S_RLOW) begin
        cnt_ff <= 32'(nand_host_pkg::OUT_STB_HIGH_CYC - 1);
      end
    end
  end

  // Busy tracking: ready must be seen low before high counts as done
  always_ff @(posedge CLOCK) begin
    if (RST)
      seen_busy_ff <= 1'b0;
    else if (state_ff != S_BUSY)
      seen_busy_ff <= 1'b0;
    else if (!READY_BUSY_N)
      seen_busy_ff <= 1'b1;
  end

  // Status pulses
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      BUSY_DONE     <= 1'b0;
      TIMEOUT_FAULT <= 1'b0;
    end else begin
      BUSY_DONE <= (state_ff == S_BUSY) && ready_seen;
      TIMEOUT_FAULT <= (state_ff == S_BUSY) && !ready_seen && tmo_hit;
    end
  end

  // Request handshake
  always_ff @(posedge CLOCK) begin
    if (RST)
      REQ_READY <= 1'b0;
    else
      REQ_READY <= can_take && !take && !REQ_READY;
  end

  // Pin drive
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      CMD_LATCH       <= 1'b0;
      ADDR_LATCH      <= 1'b0;
      CHIP_SEL_N      <= 1'b1;
      WRITE_STROBE_N  <= 1'b1;
      OUTPUT_STROBE_N <= 1'b1;
      WRITE_LOCK_N    <= 1'b0;
      IO_OUT          <= 8'h00;
      IO_OE           <= 1'b0;
    end else begin
      if (take) begin
        CMD_LATCH  <= (req_op == nand_host_pkg::OP_CMD);
        ADDR_LATCH <= (req_op == nand_host_pkg::OP_ADDR);
        CHIP_SEL_N <= !(REQ_HOLD_SELECT || req_op != nand_host_pkg::OP_WAIT);
        WRITE_LOCK_N <= lock_nxt;
        IO_OUT <= REQ_DATA;
        IO_OE  <= (req_op != nand_host_pkg::OP_RDATA) &&
                  (req_op != nand_host_pkg::OP_WAIT);
        WRITE_STROBE_N  <= !((req_op != nand_host_pkg::OP_RDATA) &&
                             (req_op != nand_host_pkg::OP_WAIT));
        OUTPUT_STROBE_N <= (req_op != nand_host_pkg::OP_RDATA);
      end else if (state_ff == S_WLOW && cnt_zero) begin
        WRITE_STROBE_N <= 1'b1;
      end else if (state_ff == S_WHIGH && cnt_zero) begin
        IO_OE <= 1'b0;
      end else if (state_ff == S_RLOW && cnt_zero) begin
        OUTPUT_STROBE_N <= 1'b1;
      end else if (state_ff == S_BUSY) begin
        CMD_LATCH       <= 1'b0;
        ADDR_LATCH      <= 1'b0;
        WRITE_STROBE_N  <= 1'b1;
        OUTPUT_STROBE_N <= 1'b1;
        if (bkind_ff != nand_host_pkg::BUSY_READ)
          WRITE_LOCK_N <= 1'b1;
      end
    end
  end

  // Two-entry read buffer
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wp_ff   <= 1'b0;
      rp_ff   <= 1'b0;
      fill_ff <= 2'h0;
    end else begin
      if (rd_push) begin
        rbuf_ff[wp_ff] <= IO_IN;
        wp_ff <= !wp_ff;
      end
      if (rd_pop)
        rp_ff <= !rp_ff;
      fill_ff <= fill_ff + {1'b0, rd_push} - {1'b0, rd_pop};
    end
  end

  // Read port registered from buffer head
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RD_VALID <= 1'b0;
      RD_DATA  <= 8'h00;
    end else begin
      RD_VALID <= (fill_nxt != 2'h0);
      RD_DATA  <= head_nxt;
    end
  end
endmodule
`default_nettype wire

/* inc/nand_host_pkg.sv */
// Purpose: Shared constants for the byte-wide NAND flash host sequencer
// Assumes: 250 MHz system clock
// Notes:   Strobe widths are whole clock cycles derived from ns figures
package nand_host_pkg;
  localparam int unsigned CLK_PERIOD_PS = 4000;
  // Strobe timing in ns
  localparam int unsigned WE_PULSE_NS       = 35;
  localparam int unsigned WE_HIGH_NS        = 15;
  localparam int unsigned OUT_STB_PULSE_NS  = 25;
  localparam int unsigned OUT_STB_HIGH_NS   = 25;
  localparam int unsigned WHR_NS            = 60;
  localparam int unsigned OUT_STB_ACCESS_NS = 35;
  // Busy limits
  localparam int unsigned PROG_MAX_US    = 500;
  localparam int unsigned ERASE_MAX_MS   = 3;
  // Least times round up to whole cycles
  localparam int unsigned WE_LOW_CYC  = (WE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WE_HIGH_CYC = (WE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned OUT_STB_LOW_CYC =
    (OUT_STB_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned OUT_STB_HIGH_CYC =
    (OUT_STB_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WHR_CYC     = (WHR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SAMPLE_CYC =
    (OUT_STB_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Timeout counts for program and erase busy
  localparam int unsigned PROG_TMO_CYC  = PROG_MAX_US * 1000 * 1000 / CLK_PERIOD_PS;
  localparam int unsigned ERASE_TMO_CYC = ERASE_MAX_MS * 1000 * 1000 * 1000 / CLK_PERIOD_PS;
  // Address cycles per address
  localparam int unsigned ADDR_BYTES    = 3;
  // partial program limits, kept by user
  localparam int unsigned MAIN_NOP_MAX  = 2;
  localparam int unsigned SPARE_NOP_MAX = 3;
  // Request kinds
  typedef enum logic [2:0] {
    OP_CMD   = 3'h0,
    OP_ADDR  = 3'h1,
    OP_WDATA = 3'h2,
    OP_RDATA = 3'h3,
    OP_WAIT  = 3'h4
  } op_t;
  // Busy kind for a wait request
  typedef enum logic [1:0] {
    BUSY_READ  = 2'h0,
    BUSY_PROG  = 2'h1,
    BUSY_ERASE = 2'h2
  } busy_t;
endpackage

/* testbench/nand_host_monitor.sv */
// Purpose: Pin protocol checks for the flash host
// Assumes: Bound to nand_host; figures follow the package
// Notes:   Strobe widths are 9 and 7 cycles
`timescale 1ns/1ps
`default_nettype none
module nand_host_chk (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Flash pins and read status
  input wire logic CMD_LATCH,
  input wire logic ADDR_LATCH,
  input wire logic CHIP_SEL_N,
  input wire logic WRITE_STROBE_N,
  input wire logic OUTPUT_STROBE_N,
  input wire logic WRITE_LOCK_N,
  input wire logic IO_OE,
  input wire logic READY_BUSY_N,
  input wire logic RD_VALID
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Cycle framing, strobe widths and busy behaviour
  cmd_frame_a: assert property (CMD_LATCH && !WRITE_STROBE_N |->
    !ADDR_LATCH && !CHIP_SEL_N && OUTPUT_STROBE_N && IO_OE)
    else $error("command cycle framed wrongly");
  addr_frame_a: assert property (ADDR_LATCH && !WRITE_STROBE_N |->
    !CMD_LATCH && !CHIP_SEL_N && OUTPUT_STROBE_N && IO_OE)
    else $error("address cycle framed wrongly");
  data_lock_a: assert property (!CMD_LATCH && !ADDR_LATCH &&
    !WRITE_STROBE_N |-> WRITE_LOCK_N && !CHIP_SEL_N && OUTPUT_STROBE_N)
    else $error("data write without lock high");
  we_width_a: assert property ($fell(WRITE_STROBE_N) |->
    ##1 !WRITE_STROBE_N [*8] ##1 WRITE_STROBE_N)
    else $error("write strobe width wrong");
  read_frame_a: assert property (!OUTPUT_STROBE_N |-> WRITE_STROBE_N &&
    !CMD_LATCH && !ADDR_LATCH && !CHIP_SEL_N && !IO_OE)
    else $error("read cycle framed wrongly");
  re_width_a: assert property ($fell(OUTPUT_STROBE_N) |->
    ##1 !OUTPUT_STROBE_N [*6] ##1 OUTPUT_STROBE_N)
    else $error("output strobe width wrong");
  rd_push_a: assert property ($rose(OUTPUT_STROBE_N) |-> RD_VALID)
    else $error("read byte not offered");
  lock_busy_a: assert property (!READY_BUSY_N && WRITE_LOCK_N |=>
    WRITE_LOCK_N) else $error("lock dropped while busy");
  busy_read_a: assert property (!READY_BUSY_N |-> OUTPUT_STROBE_N)
    else $error("output strobe low while busy");
endmodule
bind nand_host nand_host_chk u_chk (.CLOCK, .RST, .CMD_LATCH, .ADDR_LATCH,
  .CHIP_SEL_N, .WRITE_STROBE_N, .OUTPUT_STROBE_N, .WRITE_LOCK_N, .IO_OE,
  .READY_BUSY_N, .RD_VALID);
`default_nettype wire

/* testbench/flash_model.sv */
// Purpose: Behavioural byte-wide flash for the host bench
// Assumes: Strobe edges frame every cycle; no clock of its own
// Notes:   Busy spans are short stand-ins set by parameters
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
  parameter int PROG_NS  = 240,
  parameter int ERASE_NS = 480,
  parameter int READ_NS  = 160
) (
  // Pins from the host
  input  wire logic       cmd_latch,
  input  wire logic       addr_latch,
  input  wire logic       chip_sel_n,
  input  wire logic       write_strobe_n,
  input  wire logic       output_strobe_n,
  input  wire logic       write_lock_n,
  input  wire logic [7:0] io_out,
  // Pins to the host and bench view
  output logic [7:0]      io_in,
  output logic            ready_busy_n,
  output logic [7:0]      n_data,
  output logic [7:0]      last_data
);
  logic [7:0] last_cmd, rd_ptr, n_addr;
  int         busy_ns;
  event       go_busy;
  initial begin
    io_in = 8'h00;
    ready_busy_n = 1'b1;
    n_data = 8'h00;
  end
  always @(go_busy) begin
    #20 ready_busy_n = 1'b0;
    #(busy_ns) ready_busy_n = 1'b1;
  end
  always @(posedge write_strobe_n) begin
    if (!chip_sel_n && output_strobe_n) begin
      if (cmd_latch && !addr_latch) begin
        last_cmd = io_out;
        n_addr = 8'h00;
        rd_ptr = 8'h00;
        busy_ns = (io_out == 8'h10) ? PROG_NS : ERASE_NS;
        if (write_lock_n && (io_out == 8'h10 || io_out == 8'hd0))
          ->go_busy;
      end
      if (addr_latch && !cmd_latch) begin
        n_addr = n_addr + 8'h01;
        busy_ns = READ_NS;
        if (n_addr == 8'h03 && last_cmd == 8'h00)
          ->go_busy;
      end
      if (!cmd_latch && !addr_latch && write_lock_n) begin
        last_data = io_out;
        n_data = n_data + 8'h01;
      end
    end
  end
  always @(negedge output_strobe_n) begin
    if (!chip_sel_n && write_strobe_n) begin
      #8 io_in = 8'ha0 + rd_ptr;
      rd_ptr = rd_ptr + 8'h01;
    end
  end
  // Released bus shows the inverse of the last byte
  always @(posedge output_strobe_n) begin
    #12 io_in = ~io_in;
  end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: Self-checking bench for the flash host sequencer
// Assumes: Flash model on the pins; short busy timeouts
// Notes:   Program, locked program, erase and stalled reads
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int PTMO = 200;
  logic       clock, rst, req_valid, req_ready, lock_n, rd_valid, rd_ready;
  logic       busy_done, tmo_fault, cle, ale, cs_n, we_n, os_n, wp_n;
  logic       io_oe, rb_n, hold;
  logic [2:0] op;
  logic [1:0] kind;
  logic [7:0] req_data, rd_data, io_out, io_in, n_data, last_data;
  int         num_errors, n_checks, cycles;
  // Design and flash partner
  nand_host #(.PROG_TMO(PTMO), .ERASE_TMO(400)) DUT (.CLOCK(clock),
    .RST(rst), .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_OP(op),
    .REQ_BUSY_KIND(kind), .REQ_HOLD_SELECT(hold), .REQ_LOCK_N(lock_n),
    .REQ_DATA(req_data), .RD_VALID(rd_valid), .RD_READY(rd_ready),
    .RD_DATA(rd_data), .BUSY_DONE(busy_done), .TIMEOUT_FAULT(tmo_fault),
    .CMD_LATCH(cle), .ADDR_LATCH(ale), .CHIP_SEL_N(cs_n),
    .WRITE_STROBE_N(we_n), .OUTPUT_STROBE_N(os_n), .WRITE_LOCK_N(wp_n),
    .IO_OUT(io_out), .IO_OE(io_oe), .IO_IN(io_in), .READY_BUSY_N(rb_n));
  flash_model flash (.cmd_latch(cle), .addr_latch(ale), .chip_sel_n(cs_n),
    .write_strobe_n(we_n), .output_strobe_n(os_n), .write_lock_n(wp_n),
    .io_out(io_out), .io_in(io_in), .ready_busy_n(rb_n), .n_data(n_data),
    .last_data(last_data));
  always #2 clock = ~clock;
  // Cycle ceiling against hangs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      test_done;
    end
  end
  task automatic test_done;
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One request held until taken, for at most 200 cycles
  task automatic send(input logic [2:0] o, input logic [7:0] d,
                      input logic l, input logic [1:0] k);
    @(posedge clock);
    #1 op = o;
    req_data = d;
    lock_n = l;
    kind = k;
    req_valid = 1'b1;
    repeat (200) begin
      @(posedge clock);
      if (req_ready === 1'b1) break;
    end
    #1 req_valid = 1'b0;
  endtask
  task automatic cmd_addr(input logic [7:0] c, input logic l);
    send(3'h0, c, l, 2'h0);
    for (int i = 0; i < 3; i++) send(3'h1, 8'(i), l, 2'h0);
  endtask
  task automatic await(input logic [1:0] k, output logic [1:0] got,
                       output int cyc);
    send(3'h4, 8'h00, 1'b1, k);
    got = 2'b00;
    for (cyc = 0; cyc < 1000 && got == 2'b00; cyc++) begin
      @(posedge clock);
      got = {tmo_fault, busy_done};
    end
  endtask
  task automatic pop(input logic [7:0] exp);
    repeat (100) begin
      @(posedge clock);
      if (rd_valid === 1'b1) break;
    end
    chk("rd_data", rd_data, exp);
    #1 rd_ready = 1'b1;
    @(posedge clock);
    #1 rd_ready = 1'b0;
  endtask
  // Program two bytes, then a locked program that must time out
  task automatic t_program;
    logic [1:0] got;
    int         cyc;
    cmd_addr(8'h80, 1'b1);
    send(3'h2, 8'h5a, 1'b1, 2'h0);
    send(3'h2, 8'h3c, 1'b1, 2'h0);
    send(3'h0, 8'h10, 1'b1, 2'h0);
    await(2'h1, got, cyc);
    chk("data_count", n_data, 8'h02);
    chk("last_data", last_data, 8'h3c);
    chk("prog_done", {6'h00, got}, 8'h01);
    chk("standby_sel", {7'h00, cs_n}, 8'h01);
    cmd_addr(8'h80, 1'b0);
    send(3'h2, 8'h77, 1'b1, 2'h0);
    send(3'h0, 8'h10, 1'b0, 2'h0);
    await(2'h1, got, cyc);
    chk("locked_data", n_data, 8'h03);
    chk("prog_fault", {6'h00, got}, 8'h02);
    chk("fault_late", {7'h00, cyc >= PTMO - 10}, 8'h01);
  endtask
  // Erase, then read three bytes with the receiver stalled
  task automatic t_erase_read;
    logic [1:0] got;
    int         cyc;
    cmd_addr(8'h60, 1'b1);
    send(3'h0, 8'hd0, 1'b1, 2'h0);
    await(2'h2, got, cyc);
    chk("erase_done", {6'h00, got}, 8'h01);
    cmd_addr(8'h00, 1'b1);
    hold = 1'b1;
    await(2'h0, got, cyc);
    chk("read_done", {6'h00, got}, 8'h01);
    chk("hold_select", {7'h00, cs_n}, 8'h00);
    send(3'h3, 8'h00, 1'b1, 2'h0);
    send(3'h3, 8'h00, 1'b1, 2'h0);
    fork
      send(3'h3, 8'h00, 1'b1, 2'h0);
    join_none
    repeat (40) @(posedge clock);
    chk("full_stall", {7'h00, os_n}, 8'h01);
    for (int i = 0; i < 3; i++) pop(8'ha0 + 8'(i));
  endtask
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    req_valid = 1'b0;
    rd_ready = 1'b0;
    op = 3'h0;
    kind = 2'h0;
    lock_n = 1'b1;
    hold = 1'b0;
    req_data = 8'h00;
    repeat (16) @(posedge clock);
    #1 rst = 1'b0;
    t_program;
    t_erase_read;
    test_done;
  end
endmodule
`default_nettype wire
